// >>> src/bfi_pkg.sv
// Shared constants for the breaker-fail and indication block.
// Assumes a 100 MHz system clock and an APB register port.
package bfi_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int N_STAGE = 4;
  localparam int N_PHASE = 4;
  localparam int N_SET = 4;
  // Register byte addresses
  localparam logic [7:0] A_FUNC = 8'h00;
  localparam logic [7:0] A_ROUTE = 8'h04;
  localparam logic [7:0] A_BANK = 8'h08;
  localparam logic [7:0] A_CMD = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_IRQ_STAT = 8'h14;
  localparam logic [7:0] A_IRQ_MASK = 8'h18;
  localparam logic [7:0] A_SET_MAIN = 8'h20;
  localparam logic [7:0] A_SET_SECOND = 8'h30;
  localparam logic [7:0] A_SET_ACTIVE = 8'h40;
  localparam logic [7:0] A_SET_MASK = 8'hF0;
  // Field positions
  localparam int F_BF_EN = 3;
  localparam int F_TRIP_LATCH = 6;
  localparam int F_TS1_AUX = 0;
  localparam int F_CMD_BANK_GO = 0;
  localparam int F_CMD_BANK_VAL = 1;
  localparam int F_CMD_TRIP_CLR = 2;
  localparam int F_SET_BF_DELAY = 0;
  // Reset values
  localparam logic [23:0] FUNC_RST = 24'h000008;
  localparam logic [23:0] ROUTE_RST = 24'h00F00F;
  localparam logic [31:0] BF_DELAY_MS_RST = 32'h0000006E;
  // Display codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_BF = 4'h9;
  localparam logic [3:0] CODE_FAULT_RED = 4'h1;
  // Interrupt bits
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_BF = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_START = 3;
  localparam int N_IRQ = 4;
  typedef enum logic [1:0] {
    BF_IDLE = 2'b00,
    BF_RUN = 2'b01,
    BF_TRIPPED = 2'b11
  } bfi_bf_state_t;
endpackage

// >>> src/bfi_stage_ind.sv
// Start and operate indication latch for one protection stage.
// Assumes start/operate inputs synchronous to i_mclk.
`timescale 1ns/100ps
module bfi_stage_ind (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_operate,
  input wire logic i_manual,
  input wire logic i_clear,
  output logic o_start_ind,
  output logic o_op_ind
);
  logic start_ff;
  logic op_ff;
  logic seen_op_ff;

  // Set wins over the push-button clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      op_ff <= 1'b0;
    end else begin
      op_ff <= i_operate | (op_ff & ~i_clear);
    end
  end

  // Remembers an operate during the current start episode
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      seen_op_ff <= 1'b0;
    end else if (!i_start) begin
      seen_op_ff <= 1'b0;
    end else begin
      seen_op_ff <= seen_op_ff | i_operate;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      start_ff <= 1'b0;
    end else if (i_start) begin
      start_ff <= 1'b1;
    end else if (i_clear) begin
      start_ff <= 1'b0;
    end else if (!i_manual && !seen_op_ff && !op_ff) begin
      start_ff <= 1'b0;
    end
  end

  assign o_start_ind = start_ff;
  assign o_op_ind = op_ff;
endmodule

// >>> src/bfi_top.sv
// Breaker-fail delay, setting banks, output routing and front indication.
// Assumes stage, button and fault inputs synchronous to i_mclk; APB slave.
// Notes on behaviour
// - Aux trip rises when main trip stays on with fault past the delay.
// - Bit 3 of function switch group a enables breaker-fail timing.
// - Two banks of settings are held and exactly one is active.
// - Bank changes by serial command, external input or menu value.
// - Routing group c makes the first output a start or an aux trip.
// - Group a routes start and main trip, group b the extra trips.
// - One trip lamp lights on operation of any stage.
// - Shown operation code stays until the reset push-button.
// - Indication latches never feed protection or output logic.
// - Start indication self-clears unless manual reset is selected or the stage operated.
// - Codes 1-8 are start/operate per stage, code 9 is breaker fail.
// - Phase indicators latch on operation, cleared by reset button.
// - A self-supervision fault lights its lamp and drives its relay.
// - Fault display shows red digit one and a green fault number.
// - Latched main trip clears on both buttons or a serial command.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module bfi_top
  import bfi_pkg::*;
#(
  parameter int P_CYC_PER_MS = CYC_PER_MS
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [N_STAGE-1:0] i_stage_start,
  input wire logic [N_STAGE-1:0] i_stage_operate,
  input wire logic [N_PHASE-1:0] i_phase_over,
  input wire logic i_fault_present,
  input wire logic i_external_control_in,
  input wire logic i_btn_reset,
  input wire logic i_btn_program,
  input wire logic i_self_fault,
  input wire logic [3:0] i_fault_num,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_start_or_aux_trip_out,
  output logic o_main_trip_out,
  output logic o_start_out,
  output logic o_extra_trip_out_a,
  output logic o_extra_trip_out_b,
  output logic o_trip_lamp,
  output logic o_internal_fault_alarm,
  output logic o_fault_lamp,
  output logic [3:0] o_disp_code,
  output logic [3:0] o_disp_green,
  output logic o_disp_red,
  output logic [N_PHASE-1:0] o_phase_ind,
  output logic o_active_bank
);
  logic [23:0] func_ff;
  logic [23:0] route_ff;
  logic bank_menu_ff;
  logic bank_ff;
  logic ext_q_ff;
  logic [31:0] set_mem [2][N_SET];
  logic [N_IRQ-1:0] irq_stat_ff;
  logic [N_IRQ-1:0] irq_mask_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic main_trip_ff;
  logic main_q_ff;
  logic aux_ff;
  logic ts1_ff;
  logic start_out_ff;
  logic xa_ff;
  logic xb_ff;
  logic lamp_ff;
  logic irf_ff;
  logic [3:0] code_ff;
  logic [3:0] green_ff;
  logic red_ff;
  logic [N_PHASE-1:0] phase_ff;
  logic bf_ind_ff;
  logic btn_q_ff;
  logic start_q_ff;
  bfi_bf_state_t bf_state_ff;
  bfi_bf_state_t nxt_bf_state;
  logic [31:0] pre_ff;
  logic [31:0] ms_ff;
  logic [N_STAGE-1:0] start_ind;
  logic [N_STAGE-1:0] op_ind;
  logic [3:0] nxt_code;
  logic wr;
  logic rd;
  logic btn_clear;
  logic trip_clear;
  logic cmd_trip_clr;
  logic main_trip_now;
  logic main_rise;
  logic bf_fire;
  logic [7:0] base_off;
  logic [1:0] word_idx;
  logic [N_IRQ-1:0] irq_ev;
  logic [31:0] rd_word;
  logic rd_ok;

  assign wr = i_psel & i_penable & pready_ff & i_pwrite;
  assign rd = i_psel & i_penable & ~pready_ff;
  assign base_off = i_paddr & A_SET_MASK;
  assign word_idx = i_paddr[3:2];
  assign cmd_trip_clr = wr & (i_paddr == A_CMD) & i_pwdata[F_CMD_TRIP_CLR];
  assign btn_clear = i_btn_reset & ~btn_q_ff & ~i_btn_program;
  assign trip_clear = (i_btn_reset & i_btn_program) | cmd_trip_clr;

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= rd;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (i_paddr)
      A_FUNC: rd_word = {8'h00, func_ff};
      A_ROUTE: rd_word = {8'h00, route_ff};
      A_BANK: rd_word = {31'h00000000, bank_menu_ff};
      A_CMD: rd_word = 32'h00000000;
      A_STATUS: rd_word = {11'h000, bank_ff, aux_ff, main_trip_ff, irf_ff,
                           phase_ff, red_ff, green_ff, code_ff, lamp_ff,
                           3'h0};
      A_IRQ_STAT: rd_word = {28'h0000000, irq_stat_ff};
      A_IRQ_MASK: rd_word = {28'h0000000, irq_mask_ff};
      default: begin
        if (i_paddr[1:0] != 2'h0) begin
          rd_ok = 1'b0;
        end else if (base_off == A_SET_MAIN) begin
          rd_word = set_mem[0][word_idx];
        end else if (base_off == A_SET_SECOND) begin
          rd_word = set_mem[1][word_idx];
        end else if (base_off == A_SET_ACTIVE) begin
          rd_word = set_mem[bank_ff][word_idx];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (rd) begin
      prdata_ff <= i_pwrite ? 32'h00000000 : rd_word;
      pslverr_ff <= ~rd_ok;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      func_ff <= FUNC_RST;
      route_ff <= ROUTE_RST;
      irq_mask_ff <= '0;
    end else if (wr) begin
      if (i_paddr == A_FUNC) func_ff <= i_pwdata[23:0];
      if (i_paddr == A_ROUTE) route_ff <= i_pwdata[23:0];
      if (i_paddr == A_IRQ_MASK) irq_mask_ff <= i_pwdata[N_IRQ-1:0];
    end
  end

  // Two full banks; only the active one steers the timer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int b = 0; b < 2; b++) begin
        for (int w = 0; w < N_SET; w++) begin
          set_mem[b][w] <= (w == F_SET_BF_DELAY) ? BF_DELAY_MS_RST : '0;
        end
      end
    end else if (wr && i_paddr[1:0] == 2'h0) begin
      if (base_off == A_SET_MAIN) set_mem[0][word_idx] <= i_pwdata;
      if (base_off == A_SET_SECOND) set_mem[1][word_idx] <= i_pwdata;
    end
  end

  // In one cycle the menu write beats the serial command, which beats the external input
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bank_menu_ff <= 1'b0;
      bank_ff <= 1'b0;
      ext_q_ff <= 1'b0;
    end else begin
      ext_q_ff <= i_external_control_in;
      if (wr && i_paddr == A_BANK) begin
        bank_menu_ff <= i_pwdata[0];
        bank_ff <= i_pwdata[0];
      end else if (wr && i_paddr == A_CMD && i_pwdata[F_CMD_BANK_GO]) begin
        bank_ff <= i_pwdata[F_CMD_BANK_VAL];
      end else if (i_external_control_in != ext_q_ff) begin
        bank_ff <= i_external_control_in;
      end
    end
  end

  // Protection path reads stage inputs only, never the latches
  assign main_trip_now = |(i_stage_operate & route_ff[7:4]);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      main_trip_ff <= 1'b0;
    end else if (main_trip_now) begin
      main_trip_ff <= 1'b1;
    end else if (!func_ff[16+F_TRIP_LATCH] || trip_clear) begin
      main_trip_ff <= 1'b0;
    end
  end

  assign main_rise = main_trip_ff & ~main_q_ff;
  assign bf_fire = (bf_state_ff == BF_RUN) & i_fault_present
                   & (ms_ff >= set_mem[bank_ff][F_SET_BF_DELAY]);

  always_comb begin
    nxt_bf_state = bf_state_ff;
    case (bf_state_ff)
      BF_IDLE: begin
        if (main_rise && func_ff[F_BF_EN] && i_fault_present) begin
          nxt_bf_state = BF_RUN;
        end
      end
      BF_RUN: begin
        if (!i_fault_present || !main_trip_ff || !func_ff[F_BF_EN]) begin
          nxt_bf_state = BF_IDLE;
        end else if (bf_fire) begin
          nxt_bf_state = BF_TRIPPED;
        end
      end
      BF_TRIPPED: begin
        if (!main_trip_ff) nxt_bf_state = BF_IDLE;
      end
      default: nxt_bf_state = BF_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bf_state_ff <= BF_IDLE;
      main_q_ff <= 1'b0;
    end else begin
      bf_state_ff <= nxt_bf_state;
      main_q_ff <= main_trip_ff;
    end
  end

  // Millisecond prescaler keeps the compare narrow
  always_ff @(posedge i_mclk) begin
    if (i_rst || bf_state_ff != BF_RUN) begin
      pre_ff <= '0;
      ms_ff <= '0;
    end else if (pre_ff == 32'(P_CYC_PER_MS - 1)) begin
      pre_ff <= '0;
      ms_ff <= ms_ff + 32'h00000001;
    end else begin
      pre_ff <= pre_ff + 32'h00000001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      aux_ff <= 1'b0;
      ts1_ff <= 1'b0;
      start_out_ff <= 1'b0;
      xa_ff <= 1'b0;
      xb_ff <= 1'b0;
    end else begin
      aux_ff <= (nxt_bf_state == BF_TRIPPED);
      ts1_ff <= route_ff[16+F_TS1_AUX] ? (nxt_bf_state == BF_TRIPPED)
                : |(i_stage_start & route_ff[23:20]);
      start_out_ff <= |(i_stage_start & route_ff[3:0]);
      xa_ff <= |(i_stage_operate & route_ff[11:8]);
      xb_ff <= |(i_stage_operate & route_ff[15:12]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_STAGE; g++) begin : g_stage
      bfi_stage_ind u_ind (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(i_stage_start[g]),
        .i_operate(i_stage_operate[g]),
        .i_manual(func_ff[8+g]),
        .i_clear(btn_clear),
        .o_start_ind(start_ind[g]),
        .o_op_ind(op_ind[g])
      );
    end
  endgenerate

  // Breaker fail outranks operate codes, which outrank start codes
  always_comb begin
    nxt_code = CODE_NONE;
    for (int s = 0; s < N_STAGE; s++) begin
      if (start_ind[s] && nxt_code == CODE_NONE) nxt_code = 4'(2 * s + 1);
    end
    for (int s = 0; s < N_STAGE; s++) begin
      if (op_ind[s]) nxt_code = 4'(2 * s + 2);
    end
    if (bf_ind_ff) nxt_code = CODE_BF;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      btn_q_ff <= 1'b0;
      bf_ind_ff <= 1'b0;
      phase_ff <= '0;
      lamp_ff <= 1'b0;
    end else begin
      btn_q_ff <= i_btn_reset;
      bf_ind_ff <= bf_fire | (bf_ind_ff & ~btn_clear);
      if (|i_stage_operate) begin
        phase_ff <= phase_ff | i_phase_over;
      end else if (btn_clear) begin
        phase_ff <= '0;
      end
      lamp_ff <= |i_stage_operate | (lamp_ff & ~btn_clear);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irf_ff <= 1'b0;
      code_ff <= CODE_NONE;
      green_ff <= 4'h0;
      red_ff <= 1'b0;
    end else begin
      irf_ff <= i_self_fault;
      red_ff <= i_self_fault;
      green_ff <= i_self_fault ? i_fault_num : 4'h0;
      code_ff <= i_self_fault ? CODE_FAULT_RED : nxt_code;
    end
  end

  assign irq_ev = {(|i_stage_start) & ~start_q_ff, i_self_fault & ~irf_ff,
                   bf_fire, main_rise};

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_stat_ff <= '0;
      start_q_ff <= 1'b0;
    end else begin
      start_q_ff <= |i_stage_start;
      if (wr && i_paddr == A_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~i_pwdata[N_IRQ-1:0]) | irq_ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_ev;
      end
    end
  end

  logic irq_ff;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_irq = irq_ff;
  assign o_start_or_aux_trip_out = ts1_ff;
  assign o_main_trip_out = main_trip_ff;
  assign o_start_out = start_out_ff;
  assign o_extra_trip_out_a = xa_ff;
  assign o_extra_trip_out_b = xb_ff;
  assign o_trip_lamp = lamp_ff;
  assign o_internal_fault_alarm = irf_ff;
  assign o_fault_lamp = irf_ff;
  assign o_disp_code = code_ff;
  assign o_disp_green = green_ff;
  assign o_disp_red = red_ff;
  assign o_phase_ind = phase_ff;
  assign o_active_bank = bank_ff;
endmodule

// >>> verification/bfi_top_assertions.sv
// Port-level checker for the breaker-fail and indication block.
// Assumes one clock i_mclk and synchronous active-high i_rst.
`timescale 1ns/100ps
module bfi_top_checker
  import bfi_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [N_STAGE-1:0] i_stage_operate,
  input wire logic i_fault_present,
  input wire logic i_btn_reset,
  input wire logic i_self_fault,
  input wire logic [3:0] i_fault_num,
  input wire logic o_pready,
  input wire logic o_main_trip_out,
  input wire logic o_trip_lamp,
  input wire logic o_internal_fault_alarm,
  input wire logic o_fault_lamp,
  input wire logic [3:0] o_disp_code,
  input wire logic [3:0] o_disp_green,
  input wire logic o_disp_red,
  input wire logic [N_PHASE-1:0] o_phase_ind
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_trip_lamp_on: assert property (
    |i_stage_operate |-> ##[1:2] o_trip_lamp) else $error("no trip lamp");
  a_fault_relay: assert property (
    i_self_fault |-> ##[1:2] (o_internal_fault_alarm && o_fault_lamp))
    else $error("no fault alarm");
  a_fault_code_shown: assert property (
    (i_self_fault && $stable(i_fault_num)) [*3] |-> o_disp_red &&
    o_disp_code == CODE_FAULT_RED && o_disp_green == i_fault_num)
    else $error("bad fault code");
  a_code_in_range: assert property (
    o_disp_code <= CODE_BF) else $error("code out of range");
  a_phase_ind_hold: assert property (
    $changed(o_phase_ind) |-> $past(|i_stage_operate) ||
    $past(i_btn_reset) || $past(i_btn_reset, 2))
    else $error("phase indicator changed alone");
  a_op_code_hold: assert property (
    o_disp_code != CODE_NONE && !o_disp_code[0] && !i_btn_reset &&
    !$past(i_btn_reset) && !$past(i_btn_reset, 2) |=>
    o_disp_code != CODE_NONE) else $error("operate code lost");
  a_main_trip_cause: assert property (
    $rose(o_main_trip_out) |-> $past(|i_stage_operate))
    else $error("main trip without operate");
  a_bf_code_cause: assert property (
    $rose(o_disp_code == CODE_BF) |-> $past(o_main_trip_out) &&
    $past(i_fault_present)) else $error("breaker fail without cause");
  a_pready_one_wait: assert property (
    i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
endmodule
bind bfi_top bfi_top_checker bfi_top_checker_i (.i_mclk, .i_rst, .i_psel,
  .i_penable, .i_stage_operate, .i_fault_present, .i_btn_reset,
  .i_self_fault, .i_fault_num, .o_pready, .o_main_trip_out, .o_trip_lamp,
  .o_internal_fault_alarm, .o_fault_lamp, .o_disp_code, .o_disp_green,
  .o_disp_red, .o_phase_ind);

// >>> verification/bfi_breaker_model.sv
// Breaker model: fault current flows until the tripped breaker opens.
// Assumes the trip coil is driven by the block's main trip output.
`timescale 1ns/100ps
module bfi_breaker_model #(
  parameter int P_OPEN_CYC = 5
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_fault_on,
  input wire logic i_stuck,
  input wire logic i_trip,
  output logic o_fault_present
);
  int open_cnt_ff;
  // A stuck breaker never opens, so the fault stays for the backup trip
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_fault_on) begin
      open_cnt_ff <= 0;
    end else if (i_trip && !i_stuck && open_cnt_ff < P_OPEN_CYC) begin
      open_cnt_ff <= open_cnt_ff + 1;
    end
  end
  assign o_fault_present = i_fault_on && (open_cnt_ff != P_OPEN_CYC);
endmodule

// >>> verification/bfi_top_tb_top.sv
// Self-checking bench for the breaker-fail and indication block.
// Polls APB pready with no fixed wait count; breaker model on far side.
`timescale 1ns/100ps
module bfi_top_tb_top;
  import bfi_pkg::*;
  logic i_mclk = 1'h0;
  logic i_rst = 1'h1;
  logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0] i_stage_start = 4'h0, i_stage_operate = 4'h0;
  logic [3:0] i_phase_over = 4'h0, i_fault_num = 4'h0;
  logic i_external_control_in = 1'h0, i_btn_reset = 1'h0;
  logic i_btn_program = 1'h0, i_self_fault = 1'h0;
  logic fault_on = 1'h0, stuck = 1'h0, i_fault_present;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_irq, o_start_or_aux_trip_out, o_start_out;
  logic o_main_trip_out, o_extra_trip_out_a, o_extra_trip_out_b;
  logic o_trip_lamp, o_internal_fault_alarm, o_fault_lamp, o_disp_red;
  logic o_active_bank;
  logic [3:0] o_disp_code, o_disp_green, o_phase_ind;
  int error_cnt = 0, num_checks = 0;
  logic [31:0] seed = 32'hDFF8A93D;
  logic [32:0] exp_q[$];
  always #5 i_mclk = ~i_mclk;
  bfi_top #(.P_CYC_PER_MS(10)) bfi_top_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_stage_start(i_stage_start),
    .i_stage_operate(i_stage_operate), .i_phase_over(i_phase_over),
    .i_fault_present(i_fault_present),
    .i_external_control_in(i_external_control_in),
    .i_btn_reset(i_btn_reset), .i_btn_program(i_btn_program),
    .i_self_fault(i_self_fault), .i_fault_num(i_fault_num),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_irq(o_irq), .o_start_or_aux_trip_out(o_start_or_aux_trip_out),
    .o_main_trip_out(o_main_trip_out), .o_start_out(o_start_out),
    .o_extra_trip_out_a(o_extra_trip_out_a),
    .o_extra_trip_out_b(o_extra_trip_out_b), .o_trip_lamp(o_trip_lamp),
    .o_internal_fault_alarm(o_internal_fault_alarm),
    .o_fault_lamp(o_fault_lamp), .o_disp_code(o_disp_code),
    .o_disp_green(o_disp_green), .o_disp_red(o_disp_red),
    .o_phase_ind(o_phase_ind), .o_active_bank(o_active_bank));
  bfi_breaker_model bfi_breaker_model_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_fault_on(fault_on), .i_stuck(stuck), .i_trip(o_main_trip_out),
    .o_fault_present(i_fault_present));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge i_mclk);
    if (!w) exp_q.push_back(e);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    // No cycle count assumed; only the watchdog ends a hung wait
    while (o_pready !== 1'h1) @(posedge i_mclk);
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  always @(posedge i_mclk) begin
    if (i_psel && i_penable && o_pready === 1'h1 && !i_pwrite &&
      exp_q.size() > 0) begin
      chk({o_pslverr, o_prdata}, exp_q.pop_front());
    end
  end
  task wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task press(input logic prog);
    @(posedge i_mclk);
    i_btn_reset <= 1'h1;
    i_btn_program <= prog;
    repeat (2) @(posedge i_mclk);
    i_btn_reset <= 1'h0;
    i_btn_program <= 1'h0;
    wt(2);
    chk(o_disp_code & {4{!prog}}, 33'h0);
    chk({o_trip_lamp, o_phase_ind} & {5{!prog}}, 33'h0);
  endtask
  task op_pulse();
    @(posedge i_mclk);
    i_stage_operate <= 4'h1;
    repeat (3) @(posedge i_mclk);
    i_stage_operate <= 4'h0;
    wt(3);
  endtask
  task tally_and_finish();
    chk(33'(exp_q.size()), 33'h0);
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'h0;
    apb(1'h0, A_FUNC, 32'h0, {9'h0, FUNC_RST});
    apb(1'h0, A_ROUTE, 32'h0, {9'h0, ROUTE_RST});
    apb(1'h0, A_SET_MAIN, 32'h0, {1'h0, BF_DELAY_MS_RST});
    apb(1'h0, 8'h1C, 32'h0, {1'h1, 32'h0});
    $display("test reset_values done");
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      apb(1'h1, A_ROUTE, {8'h0, r[23:20], 4'h0, r[15:0]}, 33'h0);
      @(posedge i_mclk);
      i_stage_start <= r[27:24];
      i_stage_operate <= r[31:28];
      wt(2);
      chk(o_start_out, |(r[27:24] & r[3:0]));
      chk(o_main_trip_out, |(r[31:28] & r[7:4]));
      chk(o_extra_trip_out_a, |(r[31:28] & r[11:8]));
      chk(o_extra_trip_out_b, |(r[31:28] & r[15:12]));
      chk(o_start_or_aux_trip_out, |(r[27:24] & r[23:20]));
    end
    @(posedge i_mclk);
    i_stage_start <= 4'h0;
    i_stage_operate <= 4'h0;
    press(1'h0);
    $display("test routing done");
    @(posedge i_mclk);
    i_stage_start <= 4'h2;
    wt(3);
    chk(o_disp_code, 33'h3);
    @(posedge i_mclk);
    i_stage_start <= 4'h0;
    wt(3);
    chk(o_disp_code, 33'h0);
    apb(1'h1, A_FUNC, 32'h208, 33'h0);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_mclk);
      i_stage_start <= 4'h1 << s;
      i_phase_over <= 4'(s + 1);
      wt(3);
      chk(o_disp_code, 33'(2 * s + 1));
      @(posedge i_mclk);
      i_stage_operate <= 4'h1 << s;
      wt(3);
      @(posedge i_mclk);
      i_stage_start <= 4'h0;
      i_stage_operate <= 4'h0;
      i_phase_over <= 4'h0;
      wt(3);
      chk(o_disp_code, 33'(2 * s + 2));
      chk(o_phase_ind, 33'(s + 1));
      chk(o_trip_lamp, 33'h1);
      press(1'h0);
    end
    $display("test indication done");
    apb(1'h1, A_ROUTE, 32'hF0, 33'h0);
    apb(1'h1, A_IRQ_STAT, 32'hF, 33'h0);
    apb(1'h1, A_IRQ_MASK, 32'h1, 33'h0);
    apb(1'h1, A_FUNC, 32'h400008, 33'h0);
    op_pulse();
    chk({o_irq, o_main_trip_out}, 33'h3);
    apb(1'h0, A_IRQ_STAT, 32'h0, 33'h1);
    apb(1'h1, A_IRQ_STAT, 32'h1, 33'h0);
    apb(1'h1, A_CMD, 32'h4, 33'h0);
    apb(1'h1, A_IRQ_MASK, 32'h0, 33'h0);
    wt(2);
    chk({o_irq, o_main_trip_out}, 33'h0);
    op_pulse();
    chk({o_irq, o_main_trip_out}, 33'h1);
    press(1'h1);
    chk(o_main_trip_out, 33'h0);
    $display("test irq_latch done");
    apb(1'h1, A_FUNC, 32'h8, 33'h0);
    apb(1'h1, A_SET_MAIN, 32'h3, 33'h0);
    apb(1'h1, A_SET_SECOND, 32'h7, 33'h0);
    apb(1'h0, A_SET_ACTIVE, 32'h0, 33'h3);
    apb(1'h1, A_CMD, 32'h3, 33'h0);
    wt(1);
    chk(o_active_bank, 33'h1);
    apb(1'h0, A_SET_ACTIVE, 32'h0, 33'h7);
    @(posedge i_mclk);
    i_external_control_in <= 1'h1;
    @(posedge i_mclk);
    i_external_control_in <= 1'h0;
    wt(3);
    chk(o_active_bank, 33'h0);
    apb(1'h1, A_BANK, 32'h1, 33'h0);
    wt(1);
    chk(o_active_bank, 33'h1);
    apb(1'h1, A_BANK, 32'h0, 33'h0);
    $display("test banks done");
    apb(1'h1, A_ROUTE, 32'h100F0, 33'h0);
    for (int c = 0; c < 3; c++) begin
      apb(1'h1, A_FUNC, (c == 2) ? 32'h0 : 32'h8, 33'h0);
      @(posedge i_mclk);
      fault_on <= 1'h1;
      stuck <= (c != 1);
      i_stage_operate <= 4'h1;
      wt(30);
      chk(o_start_or_aux_trip_out, 33'h0);
      wt(10);
      chk(o_start_or_aux_trip_out, c == 0);
      chk(o_disp_code == CODE_BF, c == 0);
      @(posedge i_mclk);
      i_stage_operate <= 4'h0;
      fault_on <= 1'h0;
      press(1'h0);
    end
    $display("test breaker_fail done");
    r = rnd();
    @(posedge i_mclk);
    i_self_fault <= 1'h1;
    i_fault_num <= r[3:0];
    wt(4);
    chk({o_internal_fault_alarm, o_fault_lamp}, 33'h3);
    chk({o_disp_red, o_disp_green, o_disp_code}, {24'h0, 1'h1, r[3:0],
      CODE_FAULT_RED});
    $display("test self_fault done");
    tally_and_finish();
  end
endmodule
